//--- core/ptm_top.sv
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO; the writer sees o_in_ready drop when full.
module ptm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk, // Clock.
   input wire logic i_arst_n, // Async reset, active low.
   input wire logic i_in_valid, // Write request.
   output logic o_in_ready, // Not full.
   input wire logic [WIDTH-1:0] i_in_data, // Write data.
   output logic o_out_valid, // Not empty.
   input wire logic i_out_ready, // Read accept.
   output logic [WIDTH-1:0] o_out_data // Head word.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic push, pop;

   // Pointers carry an extra wrap bit so full and empty stay distinct.
   always_comb begin
      o_out_valid = (wp_r != rp_r);
      o_in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
      push = i_in_valid && o_in_ready;
      pop = o_out_valid && i_out_ready;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      o_out_data = mem[rp_r[AW-1:0]];
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage has no reset; only words behind the write pointer are read.
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= i_in_data;
      end
   end
endmodule : ptm_fifo

module ptm_top #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic i_clk, // 200 MHz clock.
   input wire logic i_arst_n, // Async reset, active low.
   input wire ptm_pkg::ptm_req_t i_req, // Management register request.
   output logic [15:0] o_rdata, // Read data, one cycle after rd.
   input wire ptm_pkg::ptm_op_t i_op_mode, // Operating mode.
   input wire ptm_pkg::ptm_spd_t i_speed, // Current speed.
   input wire logic i_power_down_pin, // Power-down pin, active high.
   input wire logic i_mirror_strap, // Mirror strap level.
   input wire logic i_partner_energy, // Link partner detected.
   input wire logic i_cd_energy, // Energy seen on pairs C and D.
   input wire logic i_gig_fail, // Gigabit link attempt failed, pulse.
   input wire logic i_fe_fail, // 100M link attempt failed, pulse.
   input wire logic i_link_up, // Link established, pulse.
   input wire logic [15:0] i_cu_events, // Copper status change pulses.
   input wire logic [15:0] i_fb_events, // Fiber status change pulses.
   input wire logic [15:0] i_lane_status, // Lane map read value.
   input wire ptm_pkg::ptm_byte_t i_mac_tx, // Byte from the MAC.
   output ptm_pkg::ptm_byte_t o_line_tx, // Byte toward the media.
   input wire ptm_pkg::ptm_byte_t i_line_rx, // Byte from the media.
   output logic o_line_rx_ready, // Receive buffer can take a byte.
   output ptm_pkg::ptm_byte_t o_mac_rx, // Byte toward the MAC.
   input wire logic i_mac_rx_ready, // MAC accepts the byte.
   output logic [4:0] o_loop, // One-hot {ext,ana,dig,pcs,mii}.
   output logic o_far_loop, // Far-end loop active.
   output logic o_int_n, // Interrupt, active low.
   output logic o_power_down, // Device powered down.
   output logic o_sleep, // Blocks powered down for sleep.
   output logic o_nlp_en, // Link pulses allowed.
   output logic [7:0] o_pair_map, // Source pair per port {D,C,B,A}.
   output logic o_polarity_inv, // Invert pair polarity.
   output logic [15:0] o_lane_map, // Lane map write value.
   output ptm_pkg::ptm_spd_t o_speed_limit // Highest speed allowed.
);
   import ptm_pkg::*;

   logic [15:0] basic_r, basic_nxt, phyc_r, phyc_nxt, cu_en_r, cu_en_nxt, fb_en_r, fb_en_nxt;
   logic [15:0] cu_st_r, cu_st_nxt, fb_st_r, fb_st_nxt, ds_r, ds_nxt, stc_r, stc_nxt;
   logic [15:0] plen_r, plen_nxt, gap_r, gap_nxt, portcfg_r, portcfg_nxt, lmap_r, lmap_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic cu_rd_r, cu_rd_nxt, fb_rd_r, fb_rd_nxt, strap_r, strap_nxt, strap_done_r, strap_done_nxt;
   logic wr, rd, start, int_clear;
   logic [4:0] req, ok, loop;
   ptm_gen_t gen_r, gen_nxt;
   logic [15:0] gcnt_r, gcnt_nxt;
   logic [14:0] glfsr_r, glfsr_nxt, clfsr_r, clfsr_nxt, pred;
   logic locked_r, locked_nxt, lost_r, lost_nxt;
   logic [1:0] match_r, match_nxt;
   logic [2:0] bad_r, bad_nxt;
   logic [15:0] errs_r, errs_nxt, bytes_r, bytes_nxt;
   ptm_byte_t gen_byte, tx_src, rx_path, line_tx_nxt, line_tx_r, fifo_in;
   logic [2:0] fails_r, fails_nxt;
   ptm_spd_t lim_r, lim_nxt;
   logic fifo_valid;
   logic [7:0] fifo_data;

   // Eight steps of x^15+x^14+1; the low byte of the result is the emitted byte.
   function automatic logic [14:0] lfsr8(input logic [14:0] s);
      logic [14:0] v;
      v = s;
      for (int i = 0; i < 8; i++) begin
         v = {v[13:0], v[14] ^ v[13]};
      end
      return v;
   endfunction : lfsr8

   // Counter step: wraps in continuous mode, otherwise holds at all ones.
   function automatic logic [15:0] bump(input logic [15:0] c, input logic cont);
      return (cont || c != 16'hFFFF) ? c + 16'h0001 : c;
   endfunction : bump

   // Register file; a software reset returns every writable register to its default.
   always_comb begin
      wr = i_req.wr;
      rd = i_req.rd;
      basic_nxt = basic_r;
      phyc_nxt = phyc_r;
      cu_en_nxt = cu_en_r;
      fb_en_nxt = fb_en_r;
      ds_nxt = ds_r;
      stc_nxt = stc_r;
      plen_nxt = plen_r;
      gap_nxt = gap_r;
      portcfg_nxt = portcfg_r;
      lmap_nxt = lmap_r;
      start = 1'b0;
      if (wr) begin
         unique case (i_req.addr)
            ADDR_BASIC: basic_nxt = i_req.wdata;
            ADDR_PHYC: phyc_nxt = i_req.wdata;
            ADDR_CU_EN: cu_en_nxt = i_req.wdata;
            ADDR_FB_EN: fb_en_nxt = i_req.wdata;
            ADDR_DSHIFT: ds_nxt = i_req.wdata;
            ADDR_STC: begin
               stc_nxt = i_req.wdata & ~(16'h0001 << STC_START);
               start = i_req.wdata[STC_START];
            end
            ADDR_PLEN: plen_nxt = i_req.wdata;
            ADDR_GAP: gap_nxt = i_req.wdata;
            ADDR_PORTCFG: portcfg_nxt = i_req.wdata;
            ADDR_LMAP_WR: lmap_nxt = i_req.wdata;
            default: ;
         endcase
      end
      if (wr && i_req.addr == ADDR_BASIC && i_req.wdata[BASIC_SWRST]) begin
         basic_nxt = '0;
         phyc_nxt = '0;
         cu_en_nxt = INT_EN_RST;
         fb_en_nxt = INT_EN_RST;
         ds_nxt = DS_RST;
         stc_nxt = '0;
         plen_nxt = PLEN_RST;
         gap_nxt = GAP_RST;
         portcfg_nxt = '0;
         lmap_nxt = '0;
         start = 1'b1;
      end
      strap_nxt = strap_done_r ? strap_r : i_mirror_strap;
      strap_done_nxt = 1'b1;
   end

   // Read mux, registered; undecoded addresses read zero.
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd) begin
         unique case (i_req.addr)
            ADDR_BASIC: rdata_nxt = basic_r;
            ADDR_PHYC: rdata_nxt = phyc_r;
            ADDR_CU_EN: rdata_nxt = cu_en_r;
            ADDR_CU_ST: rdata_nxt = cu_st_r;
            ADDR_FB_EN: rdata_nxt = fb_en_r;
            ADDR_FB_ST: rdata_nxt = fb_st_r;
            ADDR_DSHIFT: rdata_nxt = ds_r;
            ADDR_STC: rdata_nxt = stc_r;
            ADDR_LOCK: rdata_nxt = {13'h0000, gen_r != GEN_IDLE, lost_r, locked_r};
            ADDR_PLEN: rdata_nxt = plen_r;
            ADDR_GAP: rdata_nxt = gap_r;
            ADDR_PORTCFG: rdata_nxt = portcfg_r;
            ADDR_ERRS: rdata_nxt = errs_r;
            ADDR_BYTES: rdata_nxt = bytes_r;
            ADDR_LMAP_WR: rdata_nxt = lmap_r;
            ADDR_LMAP_RD: rdata_nxt = i_lane_status;
            default: rdata_nxt = 16'h0000;
         endcase
      end
   end

   // Sticky status; both status registers must be read before either clears.
   // A new event in the clearing cycle survives because the set is applied last.
   always_comb begin
      cu_rd_nxt = cu_rd_r | (rd && i_req.addr == ADDR_CU_ST);
      fb_rd_nxt = fb_rd_r | (rd && i_req.addr == ADDR_FB_ST);
      int_clear = cu_rd_nxt && fb_rd_nxt;
      if (int_clear) begin
         cu_rd_nxt = 1'b0;
         fb_rd_nxt = 1'b0;
      end
      cu_st_nxt = (int_clear ? 16'h0000 : cu_st_r) | i_cu_events;
      fb_st_nxt = (int_clear ? 16'h0000 : fb_st_r) | i_fb_events;
      o_int_n = !(|(cu_st_r & cu_en_r) || |(fb_st_r & fb_en_r));
   end

   // Loop availability by mode and speed, then the shallowest request wins.
   always_comb begin
      req = {stc_r[STC_EXT], stc_r[STC_ANA], stc_r[STC_DIG], stc_r[STC_PCS], basic_r[BASIC_MIILB]};
      ok = 5'h1F;
      ok[4] = (i_op_mode == OP_COPPER) && (i_speed != SPD_1000);
      unique case (i_op_mode)
         OP_COPPER: begin
            if (i_speed == SPD_10) ok[1] = 1'b0;
            if (i_speed == SPD_100) ok[0] = 1'b0;
         end
         OP_FIBER: begin
            if (i_speed == SPD_100) ok[1] = 1'b0;
            ok[3] = 1'b0;
         end
         OP_S2R: ok[4:1] = 4'h0;
         OP_R2S: begin
            ok[1] = 1'b0;
            ok[4] = 1'b0;
         end
         OP_MEDIA: begin
            if (i_speed != SPD_10) ok[0] = 1'b0;
            if (i_speed == SPD_100) ok[3] = 1'b0;
            ok[4] = 1'b0;
         end
         default: ok = 5'h00;
      endcase
      loop = req & ok;
      loop = loop & (~loop + 5'h01);
      o_loop = loop;
      o_far_loop = stc_r[STC_FAR] && (loop == 5'h00);
      o_power_down = basic_r[BASIC_PDOWN] || i_power_down_pin;
   end

   // Packet generator: packets of plen bytes separated by gap idle cycles.
   always_comb begin
      gen_nxt = gen_r;
      gcnt_nxt = gcnt_r;
      glfsr_nxt = glfsr_r;
      gen_byte = '0;
      if (!stc_r[STC_GEN] || o_power_down) begin
         gen_nxt = GEN_IDLE;
      end else begin
         unique case (gen_r)
            GEN_IDLE: begin
               gen_nxt = GEN_PKT;
               gcnt_nxt = plen_r;
            end
            GEN_PKT: begin
               glfsr_nxt = lfsr8(glfsr_r);
               gen_byte = '{valid: 1'b1, data: glfsr_nxt[7:0]};
               gcnt_nxt = gcnt_r - 16'h0001;
               if (gcnt_r <= 16'h0001) begin
                  gen_nxt = GEN_GAP;
                  gcnt_nxt = gap_r;
               end
            end
            GEN_GAP: begin
               gcnt_nxt = gcnt_r - 16'h0001;
               if (gcnt_r <= 16'h0001) begin
                  gen_nxt = GEN_PKT;
                  gcnt_nxt = plen_r;
               end
            end
            default: gen_nxt = GEN_IDLE;
         endcase
      end
   end

   // Data steering for near-end and far-end loops.
   always_comb begin
      tx_src = stc_r[STC_GEN] ? gen_byte : i_mac_tx;
      if (o_far_loop) tx_src = '0;
      rx_path = (|loop[3:0]) ? tx_src : i_line_rx;
      line_tx_nxt = (|loop[3:0]) ? ptm_byte_t'('0) : tx_src;
      if (o_far_loop) line_tx_nxt = i_line_rx;
      if (o_power_down || o_sleep) line_tx_nxt = '0;
      fifo_in = rx_path;
      if (o_far_loop) fifo_in.valid = i_line_rx.valid && stc_r[STC_FWD];
   end

   // Checker: loads received bytes until two predictions match, then locks and free-runs.
   always_comb begin
      clfsr_nxt = clfsr_r;
      locked_nxt = locked_r;
      lost_nxt = lost_r;
      match_nxt = match_r;
      bad_nxt = bad_r;
      errs_nxt = errs_r;
      bytes_nxt = bytes_r;
      pred = lfsr8(clfsr_r);
      if (start) begin
         locked_nxt = 1'b0;
         lost_nxt = 1'b0;
         match_nxt = '0;
         bad_nxt = '0;
         errs_nxt = '0;
         bytes_nxt = '0;
      end else if (stc_r[STC_CHK] && rx_path.valid) begin
         bytes_nxt = bump(bytes_r, stc_r[STC_CONT]);
         if (!locked_r) begin
            clfsr_nxt = {clfsr_r[6:0], rx_path.data};
            match_nxt = (pred[7:0] == rx_path.data) ? match_r + 2'h1 : 2'h0;
            locked_nxt = (match_nxt == LOCK_MATCHES);
            bad_nxt = '0;
         end else begin
            clfsr_nxt = pred;
            if (pred[7:0] != rx_path.data) begin
               errs_nxt = bump(errs_r, stc_r[STC_CONT]);
               bad_nxt = bad_r + 3'h1;
               if (bad_nxt == LOSE_ERRS) begin
                  locked_nxt = 1'b0;
                  lost_nxt = 1'b1;
                  match_nxt = '0;
               end
            end else begin
               bad_nxt = '0;
            end
         end
      end
   end

   // Downshift: count consecutive gigabit failures; enhanced mode can act sooner.
   always_comb begin
      fails_nxt = fails_r;
      lim_nxt = lim_r;
      if (!ds_r[DS_EN] || i_link_up) begin
         fails_nxt = '0;
         if (!ds_r[DS_EN]) lim_nxt = SPD_1000;
      end else if (i_gig_fail && lim_r == SPD_1000) begin
         fails_nxt = fails_r + 3'h1;
         if (fails_nxt >= ds_r[DS_ATT +: 3] || (ds_r[DS_ENH] && !i_cd_energy)) begin
            lim_nxt = SPD_100;
            fails_nxt = '0;
         end
      end else if (i_fe_fail && ds_r[DS_ENH] && lim_r == SPD_100) begin
         lim_nxt = SPD_10;
      end
   end

   // Sleep, mirroring and plain outputs driven from registers.
   always_comb begin
      o_sleep = !o_power_down && phyc_r[PHYC_SLEEP+1] && !i_partner_energy;
      o_nlp_en = !o_power_down && (!o_sleep || phyc_r[PHYC_SLEEP +: 2] == SLEEP_ACTIVE);
      o_polarity_inv = portcfg_r[PORTCFG_MIRROR] || strap_r;
      o_pair_map = o_polarity_inv ? 8'h1B : 8'hE4;
      o_lane_map = lmap_r;
      o_rdata = rdata_r;
      o_line_tx = line_tx_r;
      o_speed_limit = lim_r;
   end

   // Receive buffer toward the MAC; its ready throttles the line receive side.
   ptm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(fifo_in.valid),
      .o_in_ready(o_line_rx_ready),
      .i_in_data(fifo_in.data),
      .o_out_valid(fifo_valid),
      .i_out_ready(i_mac_rx_ready),
      .o_out_data(fifo_data)
   );

   assign o_mac_rx = '{valid: fifo_valid, data: fifo_data};

   // State registers.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         basic_r <= '0;
         phyc_r <= '0;
         cu_en_r <= INT_EN_RST;
         fb_en_r <= INT_EN_RST;
         cu_st_r <= '0;
         fb_st_r <= '0;
         ds_r <= DS_RST;
         stc_r <= '0;
         plen_r <= PLEN_RST;
         gap_r <= GAP_RST;
         portcfg_r <= '0;
         lmap_r <= '0;
         rdata_r <= '0;
         cu_rd_r <= 1'b0;
         fb_rd_r <= 1'b0;
         strap_r <= 1'b0;
         strap_done_r <= 1'b0;
         gen_r <= GEN_IDLE;
         gcnt_r <= '0;
         glfsr_r <= PRBS_SEED;
         clfsr_r <= '0;
         locked_r <= 1'b0;
         lost_r <= 1'b0;
         match_r <= '0;
         bad_r <= '0;
         errs_r <= '0;
         bytes_r <= '0;
         line_tx_r <= '0;
         fails_r <= '0;
         lim_r <= SPD_1000;
      end else begin
         basic_r <= basic_nxt;
         phyc_r <= phyc_nxt;
         cu_en_r <= cu_en_nxt;
         fb_en_r <= fb_en_nxt;
         cu_st_r <= cu_st_nxt;
         fb_st_r <= fb_st_nxt;
         ds_r <= ds_nxt;
         stc_r <= stc_nxt;
         plen_r <= plen_nxt;
         gap_r <= gap_nxt;
         portcfg_r <= portcfg_nxt;
         lmap_r <= lmap_nxt;
         rdata_r <= rdata_nxt;
         cu_rd_r <= cu_rd_nxt;
         fb_rd_r <= fb_rd_nxt;
         strap_r <= strap_nxt;
         strap_done_r <= strap_done_nxt;
         gen_r <= gen_nxt;
         gcnt_r <= gcnt_nxt;
         glfsr_r <= glfsr_nxt;
         clfsr_r <= clfsr_nxt;
         locked_r <= locked_nxt;
         lost_r <= lost_nxt;
         match_r <= match_nxt;
         bad_r <= bad_nxt;
         errs_r <= errs_nxt;
         bytes_r <= bytes_nxt;
         line_tx_r <= line_tx_nxt;
         fails_r <= fails_nxt;
         lim_r <= lim_nxt;
      end
   end
endmodule : ptm_top

`default_nettype wire

//--- core/ptm_pkg.sv
package ptm_pkg;
   // Register addresses on the management access port.
   localparam logic [11:0] ADDR_BASIC = 12'h000;
   localparam logic [11:0] ADDR_PHYC = 12'h010;
   localparam logic [11:0] ADDR_CU_EN = 12'h012;
   localparam logic [11:0] ADDR_CU_ST = 12'h013;
   localparam logic [11:0] ADDR_DSHIFT = 12'h014;
   localparam logic [11:0] ADDR_STC = 12'h016;
   localparam logic [11:0] ADDR_LOCK = 12'h017;
   localparam logic [11:0] ADDR_PLEN = 12'h01A;
   localparam logic [11:0] ADDR_GAP = 12'h01B;
   localparam logic [11:0] ADDR_PORTCFG = 12'h031;
   localparam logic [11:0] ADDR_ERRS = 12'h039;
   localparam logic [11:0] ADDR_BYTES = 12'h03A;
   localparam logic [11:0] ADDR_LMAP_WR = 12'h0A0;
   localparam logic [11:0] ADDR_LMAP_RD = 12'h0A1;
   localparam logic [11:0] ADDR_FB_EN = 12'hC18;
   localparam logic [11:0] ADDR_FB_ST = 12'hC19;
   // Field positions.
   localparam int BASIC_SWRST = 15;
   localparam int BASIC_MIILB = 14;
   localparam int BASIC_PDOWN = 11;
   localparam int PHYC_SLEEP = 8;
   localparam int STC_FAR = 0;
   localparam int STC_PCS = 1;
   localparam int STC_DIG = 2;
   localparam int STC_ANA = 3;
   localparam int STC_EXT = 4;
   localparam int STC_FWD = 5;
   localparam int STC_CONT = 6;
   localparam int STC_GEN = 7;
   localparam int STC_CHK = 8;
   localparam int STC_START = 9;
   localparam int LOCK_LOCKED = 0;
   localparam int LOCK_LOST = 1;
   localparam int LOCK_BUSY = 2;
   localparam int PORTCFG_MIRROR = 0;
   localparam int DS_EN = 0;
   localparam int DS_ENH = 1;
   localparam int DS_ATT = 2;
   localparam logic [1:0] SLEEP_ACTIVE = 2'h2;
   localparam logic [1:0] SLEEP_PASSIVE = 2'h3;
   // Reset values and checker lock thresholds.
   localparam logic [15:0] INT_EN_RST = 16'h0001;
   localparam logic [15:0] DS_RST = 16'h0010;
   localparam logic [15:0] PLEN_RST = 16'h0040;
   localparam logic [15:0] GAP_RST = 16'h000C;
   localparam logic [14:0] PRBS_SEED = 15'h7FFF;
   localparam logic [1:0] LOCK_MATCHES = 2'h2;
   localparam logic [2:0] LOSE_ERRS = 3'h4;

   typedef enum logic [2:0] {
      OP_COPPER = 3'h0,
      OP_FIBER = 3'h1,
      OP_R2S = 3'h2,
      OP_S2R = 3'h3,
      OP_MEDIA = 3'h4
   } ptm_op_t;

   typedef enum logic [1:0] {
      SPD_10 = 2'h0,
      SPD_100 = 2'h1,
      SPD_1000 = 2'h2
   } ptm_spd_t;

   typedef enum logic [1:0] {
      GEN_IDLE = 2'h0,
      GEN_PKT = 2'h1,
      GEN_GAP = 2'h3
   } ptm_gen_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } ptm_byte_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } ptm_req_t;
endpackage : ptm_pkg

//--- testbench/ptm_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Ties loop, mirror and power outputs to the mode inputs.
module ptm_chk (
   input wire logic i_clk, // Clock.
   input wire logic i_arst_n, // Reset.
   input wire ptm_pkg::ptm_op_t i_op_mode, // Mode.
   input wire ptm_pkg::ptm_spd_t i_speed, // Speed.
   input wire logic i_power_down_pin, // Pin.
   input wire ptm_pkg::ptm_byte_t i_line_rx, // Media in.
   input wire ptm_pkg::ptm_byte_t o_line_tx, // Media out.
   input wire logic [4:0] o_loop, // Loop point.
   input wire logic o_far_loop, // Far loop.
   input wire logic o_power_down, // Down.
   input wire logic [7:0] o_pair_map, // Pairs.
   input wire logic o_polarity_inv // Polarity.
);
   import ptm_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // One edge of grace, because the pin may pass through a flop.
   sequence pin_held; i_power_down_pin [*2]; endsequence
   sequence far_byte; o_far_loop && i_line_rx.valid; endsequence
   pin_down_a: assert property (pin_held |-> o_power_down) else $error("pin ignored");
   one_loop_a: assert property ($onehot0(o_loop)) else $error("two loops");
   far_alone_a: assert property (o_far_loop |-> o_loop == 5'h00) else $error("far with near");
   far_echo_a: assert property (far_byte |=> o_line_tx == $past(i_line_rx)) else $error("no echo");
   copper_tbl_a: assert property (i_op_mode == OP_COPPER |->
      !(i_speed == SPD_10 && o_loop[1]) && !(i_speed == SPD_100 && o_loop[0])) else $error("copper loop");
   s2r_none_a: assert property (i_op_mode == OP_S2R |-> o_loop[4:1] == 4'h0) else $error("s2r loop");
   r2s_none_a: assert property (i_op_mode == OP_R2S |-> !o_loop[4] && !o_loop[1]) else $error("r2s loop");
   pair_map_a: assert property (o_pair_map == (o_polarity_inv ? 8'h1B : 8'hE4)) else $error("pair map");
endmodule : ptm_chk
bind ptm_top ptm_chk ptm_chk_inst (.i_clk, .i_arst_n, .i_op_mode, .i_speed, .i_power_down_pin, .i_line_rx,
   .o_line_tx, .o_loop, .o_far_loop, .o_power_down, .o_pair_map, .o_polarity_inv);
`default_nettype wire

//--- testbench/ptm_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Link partner sending counting bytes, and a MAC sink that can stall.
module ptm_partner (
   input wire logic i_clk, // Clock.
   input wire logic i_send, // Send bytes.
   input wire logic i_stall, // Stall the MAC side.
   output ptm_pkg::ptm_byte_t o_line_rx, // Byte to device.
   output logic o_mac_ready // MAC accepts.
);
   import ptm_pkg::*;
   logic [7:0] cnt_r = 8'h00;
   initial o_line_rx = '0;
   // An idle line flips its data so a stale byte never repeats.
   always @(posedge i_clk) begin
      cnt_r <= i_send ? cnt_r + 8'h01 : cnt_r;
      o_line_rx <= i_send ? {1'b1, cnt_r} : {1'b0, ~o_line_rx.data};
   end
   assign o_mac_ready = !i_stall;
endmodule : ptm_partner
`default_nettype wire

//--- testbench/ptm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_top_tb;
   import ptm_pkg::*;
   logic i_clk, i_arst_n = '0, i_power_down_pin = '0, i_mirror_strap = '0, i_partner_energy = '0, i_gig_fail = '0;
   logic send = '0, stall = '0, o_line_rx_ready, i_mac_rx_ready, o_far_loop, o_int_n, o_power_down, o_sleep, o_nlp_en;
   logic o_polarity_inv, i_cd_energy = 1'b1, i_fe_fail = 1'b0;
   logic [15:0] o_rdata, o_lane_map, i_cu_events = '0, i_fb_events = '0, i_lane_status = 16'h5A3C;
   logic [4:0] o_loop;
   logic [7:0] o_pair_map;
   ptm_req_t i_req = '0;
   ptm_op_t i_op_mode = OP_COPPER;
   ptm_spd_t i_speed = SPD_1000, o_speed_limit;
   ptm_byte_t i_line_rx, o_line_tx, o_mac_rx;
   int num_errors = 0, total_checks = 0;
   ptm_top #(.FIFO_DEPTH(16)) ptm_top_inst (.i_clk, .i_arst_n, .i_req, .o_rdata, .i_op_mode, .i_speed,
      .i_power_down_pin, .i_mirror_strap, .i_partner_energy, .i_cd_energy, .i_gig_fail, .i_fe_fail,
      .i_link_up(1'b0), .i_cu_events, .i_fb_events, .i_lane_status, .i_mac_tx('0), .o_line_tx, .i_line_rx,
      .o_line_rx_ready, .o_mac_rx, .i_mac_rx_ready, .o_loop, .o_far_loop, .o_int_n, .o_power_down, .o_sleep,
      .o_nlp_en, .o_pair_map, .o_polarity_inv, .o_lane_map, .o_speed_limit);
   ptm_partner ptm_partner_inst (.i_clk, .i_send(send), .i_stall(stall), .o_line_rx(i_line_rx),
      .o_mac_ready(i_mac_rx_ready));
   // Free-running clock.
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One request per call; inputs move 1 ns after the edge.
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      tick();
      i_req = {1'b1, 1'b0, a, d};
      tick();
      i_req = '0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
      tick();
      i_req = {1'b0, 1'b1, a, 16'h0000};
      tick();
      i_req = '0;
      chk(o_rdata & m, e);
   endtask : rd
   task automatic lb(input ptm_op_t o, input ptm_spd_t s, input logic [15:0] b, input logic [15:0] c,
      input logic [4:0] e);
      i_op_mode = o;
      i_speed = s;
      wr(ADDR_BASIC, b);
      wr(ADDR_STC, c);
      chk({11'h000, o_loop}, {11'h000, e});
   endtask : lb
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   // Watchdog far beyond the few hundred cycles the tests need.
   initial begin
      repeat (6000) @(posedge i_clk);
      num_errors++;
      summarize();
   end
   initial begin
      tick(4);
      i_arst_n = 1'b1;
      rd(ADDR_CU_EN, INT_EN_RST);
      wr(12'h0FE, 16'hE720);
      rd(12'h0FE, 16'h0000);
      i_cu_events = 16'h0001;
      tick();
      i_cu_events = '0;
      chk({15'h0000, o_int_n}, 16'h0000);
      rd(ADDR_CU_ST, 16'h0001);
      chk({15'h0000, o_int_n}, 16'h0000);
      rd(ADDR_FB_ST, 16'h0000);
      chk({15'h0000, o_int_n}, 16'h0001);
      // Fiber source this time, and the status reads in the other order.
      i_fb_events = 16'h0001;
      tick();
      i_fb_events = '0;
      chk({15'h0000, o_int_n}, 16'h0000);
      rd(ADDR_FB_ST, 16'h0001);
      chk({15'h0000, o_int_n}, 16'h0000);
      rd(ADDR_CU_ST, 16'h0000);
      chk({15'h0000, o_int_n}, 16'h0001);
      wr(ADDR_BASIC, 16'h0800);
      rd(ADDR_BASIC, 16'h0800);
      i_power_down_pin = 1'b1;
      wr(ADDR_BASIC, 16'h0000);
      chk({15'h0000, o_power_down}, 16'h0001);
      i_power_down_pin = 1'b0;
      tick(2);
      chk({15'h0000, o_power_down}, 16'h0000);
      wr(ADDR_PHYC, 16'h0200);
      chk({14'h0000, o_sleep, o_nlp_en}, 16'h0003);
      wr(ADDR_PHYC, 16'h0300);
      chk({14'h0000, o_sleep, o_nlp_en}, 16'h0002);
      i_partner_energy = 1'b1;
      tick(2);
      chk({15'h0000, o_sleep}, 16'h0000);
      wr(ADDR_PORTCFG, 16'h0001);
      chk({o_pair_map, 7'h00, o_polarity_inv}, 16'h1B01);
      rd(ADDR_LMAP_RD, 16'h5A3C);
      wr(ADDR_LMAP_WR, 16'h5A3C);
      chk(o_lane_map, 16'h5A3C);
      lb(OP_COPPER, SPD_10, 16'h0000, 16'h0002, 5'h00);
      lb(OP_COPPER, SPD_100, 16'h4000, 16'h0006, 5'h02);
      lb(OP_FIBER, SPD_1000, 16'h0000, 16'h0008, 5'h00);
      lb(OP_S2R, SPD_1000, 16'h0000, 16'h001E, 5'h00);
      lb(OP_R2S, SPD_100, 16'h0000, 16'h0012, 5'h00);
      lb(OP_COPPER, SPD_1000, 16'h0000, 16'h0009, 5'h08);
      lb(OP_COPPER, SPD_1000, 16'h0000, 16'h0384, 5'h04);
      tick(300);
      rd(ADDR_LOCK, 16'h0005, 16'h0007);
      rd(ADDR_ERRS, 16'h0000);
      wr(ADDR_DSHIFT, 16'h0011);
      repeat (4) begin
         chk({14'h0000, o_speed_limit}, {14'h0000, SPD_1000});
         i_gig_fail = 1'b1;
         tick();
         i_gig_fail = 1'b0;
         tick();
      end
      chk({14'h0000, o_speed_limit}, {14'h0000, SPD_100});
      // Disabling restores gigabit; enhanced mode then falls back on one failure without C/D energy.
      wr(ADDR_DSHIFT, 16'h0000);
      wr(ADDR_DSHIFT, 16'h0013);
      chk({14'h0000, o_speed_limit}, {14'h0000, SPD_1000});
      i_cd_energy = 1'b0;
      i_gig_fail = 1'b1;
      tick();
      i_gig_fail = 1'b0;
      chk({14'h0000, o_speed_limit}, {14'h0000, SPD_100});
      i_fe_fail = 1'b1;
      tick();
      i_fe_fail = 1'b0;
      chk({14'h0000, o_speed_limit}, {14'h0000, SPD_10});
      lb(OP_COPPER, SPD_1000, 16'h0000, 16'h0021, 5'h00);
      chk({15'h0000, o_far_loop}, 16'h0001);
      stall = 1'b1;
      send = 1'b1;
      tick(24);
      chk({15'h0000, o_line_rx_ready}, 16'h0000);
      send = 1'b0;
      stall = 1'b0;
      tick(24);
      chk({15'h0000, o_mac_rx.valid}, 16'h0000);
      summarize();
   end
endmodule : ptm_top_tb
`default_nettype wire
